// >>> power_mode_pkg.sv
// shared constants, state codes and carrier structs of the power-mode sequencer
package power_mode_pkg;

  localparam int unsigned NUM_ENV    = 2;  // independent execution environments
  localparam int unsigned IRQ_W      = 8;  // interrupt request lines
  localparam int unsigned IRQ_IDX_W  = 3;  // index width of one request line
  localparam int unsigned NUM_PERIPH = 8;  // gated peripherals
  localparam int unsigned PIN_W      = 4;  // synchronised pins
  localparam int unsigned ENV_IDX_W  = 1;  // index width of one environment

  // interrupt line that carries the time-slice switch between environments
  localparam logic [IRQ_IDX_W-1:0] SLICE_IRQ_IDX = 3'h0;
  // owning environment of each interrupt line (bit i set: line i belongs to env 1)
  localparam logic [IRQ_W-1:0]     IRQ_ENV_MAP   = 8'hF0;
  localparam logic [ENV_IDX_W-1:0] ENV_FIRST     = 1'h0;
  localparam logic [ENV_IDX_W-1:0] ENV_LAST      = 1'h1;
  localparam logic [ENV_IDX_W-1:0] ENV_STEP      = 1'h1;
  // idle level of the active-low pins after reset
  localparam logic [PIN_W-1:0]     PIN_IDLE      = 4'hF;

  // operating modes
  typedef enum logic [2:0] {
    MODE_RUN     = 3'h0,  // core clocked, executing
    MODE_IDLE    = 3'h1,  // core clock off, peripherals on
    MODE_PD_RTN  = 3'h2,  // environments run their shutdown routines
    MODE_PD_STOP = 3'h3,  // global clock off, memory kept
    MODE_STANDBY = 3'h4   // core and peripheral clocks off
  } mode_t;

  // active-low external pins after synchronisation
  typedef struct packed {
    logic warn_n;   // power_down_warning_n
    logic wake_n;   // wakeup_pin_n
    logic warm_n;   // warm_reset_n
    logic cold_n;   // cold_reset_n
  } pins_t;

  // dispatch announcement on idle exit
  typedef struct packed {
    logic                 valid;  // one-cycle pulse
    logic [ENV_IDX_W-1:0] env;    // environment to resume
    logic [IRQ_IDX_W-1:0] irq;    // line that woke the core
    logic                 slice;  // woken by the slice switch
  } dispatch_t;

  // clock gate enables, changed only while the clock is low
  typedef struct packed {
    logic                  core_en;
    logic                  global_en;
    logic [NUM_PERIPH-1:0] periph_en;
  } gate_t;

endpackage : power_mode_pkg

// >>> pin_sync.sv
// three-stage synchroniser with agreement filter for the active-low pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import power_mode_pkg::*;
(
  input  wire logic  ref_clk_i,  // core reference clock
  input  wire logic  nrst_i,     // async reset, active low
  input  wire pins_t pins_i,     // raw pins
  output pins_t      pins_o      // filtered, registered levels
);

  // all synchroniser state in one struct
  typedef struct packed {
    pins_t s1;   // first stage, read only by s2
    pins_t s2;   // second stage
    pins_t s3;   // third stage
    pins_t out;  // accepted level
  } sync_t;

  sync_t st_r;   // registered state
  sync_t st_nxt; // next state

  // shift chain; a change counts once stages two and three agree
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pins_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < PIN_W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin  // stable: accept
        st_nxt.out[i] = st_r.s3[i];
      end
    end
  end

  // state register, pins idle high at reset
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, out: PIN_IDLE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pins_o = st_r.out;

endmodule : pin_sync
`default_nettype wire

// >>> power_mode_sequencer.sv
// power-mode sequencer: idle, power-down, standby and peripheral clock gating
// Function
// - idle entered when no thread is runnable
// - core clock gated off while idle
// - unmasked interrupt restarts core, ends idle
// - idle exit announces requesting thread environment
// - enabled peripherals stay clocked during idle
// - warning pin low starts power-down sequence from run or idle
// - every environment runs its shutdown routine
// - finally stop global clock, memory kept
// - standby instruction stops core, peripheral clocks
// - wake pin low restores clocks from standby
// - standby exit resumes without any reset
// - each peripheral gated individually when unused
// - cold reset is full reset, open-collector
// - wake pin only leaves standby mode
`timescale 1ns/1ps
`default_nettype none
module power_mode_sequencer
  import power_mode_pkg::*;
(
  input  wire logic                  ref_clk_i,              // free-running clock
  input  wire logic                  nrst_i,                 // async reset, active low
  input  wire logic                  power_down_warning_n_i, // supply warning pin
  input  wire logic                  wakeup_pin_n_i,         // standby wake pin
  input  wire logic                  warm_reset_n_i,         // warm reset pin
  input  wire logic                  cold_reset_n_i,         // cold reset pin level
  output logic                       cold_reset_n_o,         // cold reset drive value
  output logic                       cold_reset_n_oe_o,      // cold reset drive enable
  input  wire logic                  test_reset_req_i,       // test port system reset
  input  wire logic                  run_queue_empty_i,      // no runnable thread
  input  wire logic [IRQ_W-1:0]      irq_req_i,              // interrupt requests
  input  wire logic [IRQ_W-1:0]      irq_mask_i,             // 1 masks a line
  input  wire logic                  standby_instr_i,        // standby instruction pulse
  output logic [NUM_ENV-1:0]         pd_routine_req_o,       // run shutdown routine
  input  wire logic [NUM_ENV-1:0]    pd_routine_done_i,      // shutdown routine done
  input  wire logic [NUM_PERIPH-1:0] periph_low_power_i,     // 1 parks a peripheral
  output logic                       dispatch_valid_o,       // idle exit pulse
  output logic [ENV_IDX_W-1:0]       dispatch_env_o,         // environment to resume
  output logic [IRQ_IDX_W-1:0]       dispatch_irq_o,         // waking line
  output logic                       dispatch_slice_o,       // woken by slice switch
  output logic                       warm_resume_o,          // warm restart pulse
  output logic                       cold_restart_o,         // full reset pulse
  output logic                       core_clk_en_o,          // core clock gate enable
  output logic                       global_clk_en_o,        // global clock gate enable
  output logic [NUM_PERIPH-1:0]      periph_clk_en_o,        // peripheral gate enables
  output mode_t                      mode_o                  // current mode
);

  // lowest unmasked pending line
  function automatic logic [IRQ_IDX_W-1:0] first_irq(input logic [IRQ_W-1:0] v);
    logic [IRQ_IDX_W-1:0] idx;
    idx = '0;
    for (int i = IRQ_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = IRQ_IDX_W'(i);
      end
    end
    return idx;
  endfunction : first_irq

  // all sequencer state except the gate enables
  typedef struct packed {
    mode_t                mode;      // operating mode
    logic [ENV_IDX_W-1:0] env_idx;   // environment in shutdown
    logic [NUM_ENV-1:0]   pd_req;    // shutdown routine request
    dispatch_t            disp;      // dispatch announcement
    logic                 warn_prev; // previous warning level
    logic                 warm_res;  // warm restart pulse
    logic                 cold_res;  // full reset pulse
    logic                 cold_drv;  // pull cold reset low
  } state_t;

  state_t             st_r;        // registered state
  state_t             st_nxt;      // next state
  gate_t              gate_r;      // gate enables, falling edge
  gate_t              gate_nxt;    // next gate enables
  pins_t              pins_raw;    // raw pins
  pins_t              pins_s;      // synchronised pins
  logic [IRQ_W-1:0]   irq_live;    // unmasked pending lines
  logic [IRQ_IDX_W-1:0] irq_sel;   // chosen line
  logic               warn_fall;   // warning asserted now

  // pins pass the synchroniser on the free clock, so wake works when gated
  assign pins_raw = '{warn_n: power_down_warning_n_i, wake_n: wakeup_pin_n_i,
                      warm_n: warm_reset_n_i,         cold_n: cold_reset_n_i};

  // synchroniser for the external pins
  pin_sync u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .pins_i    (pins_raw),
    .pins_o    (pins_s)
  );

  assign irq_live  = irq_req_i & ~irq_mask_i;
  assign irq_sel   = first_irq(irq_live);
  assign warn_fall = st_r.warn_prev && !pins_s.warn_n;

  // mode sequencing
  always_comb begin
    st_nxt            = st_r;
    st_nxt.disp.valid = 1'b0;
    st_nxt.warm_res   = 1'b0;
    st_nxt.cold_res   = 1'b0;
    st_nxt.warn_prev  = pins_s.warn_n;
    st_nxt.cold_drv   = test_reset_req_i;
    unique case (st_r.mode)
      MODE_RUN: begin
        if (warn_fall) begin
          st_nxt.mode    = MODE_PD_RTN;
          st_nxt.env_idx = ENV_FIRST;
          st_nxt.pd_req  = '0;
          st_nxt.pd_req[ENV_FIRST] = 1'b1;
        end else if (standby_instr_i) begin
          st_nxt.mode = MODE_STANDBY;
        end else if (run_queue_empty_i && (irq_live == '0)) begin
          st_nxt.mode = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (warn_fall) begin
          st_nxt.mode    = MODE_PD_RTN;
          st_nxt.env_idx = ENV_FIRST;
          st_nxt.pd_req  = '0;
          st_nxt.pd_req[ENV_FIRST] = 1'b1;
        end else if (irq_live != '0) begin
          st_nxt.mode       = MODE_RUN;
          st_nxt.disp.valid = 1'b1;
          st_nxt.disp.irq   = irq_sel;
          st_nxt.disp.env   = ENV_IDX_W'(IRQ_ENV_MAP[irq_sel]);
          st_nxt.disp.slice = (irq_sel == SLICE_IRQ_IDX);
        end
      end
      MODE_PD_RTN: begin
        // one environment at a time, request held until done
        if (pd_routine_done_i[st_r.env_idx]) begin
          st_nxt.pd_req = '0;
          if (st_r.env_idx == ENV_LAST) begin
            st_nxt.mode = MODE_PD_STOP;
          end else begin
            st_nxt.env_idx = st_r.env_idx + ENV_STEP;
            st_nxt.pd_req[st_r.env_idx + ENV_STEP] = 1'b1;
          end
        end
      end
      MODE_PD_STOP: begin
        // memory kept alive; only a reset pin leaves
        if (!pins_s.warm_n) begin
          st_nxt.mode     = MODE_RUN;
          st_nxt.warm_res = 1'b1;
        end
      end
      MODE_STANDBY: begin
        // wake pin or cold reset pin leaves; wake signals no restart
        if (!pins_s.wake_n) begin
          st_nxt.mode = MODE_RUN;
        end
      end
      default: begin
        st_nxt.mode = MODE_RUN;  // illegal code recovers
      end
    endcase
    // cold reset pin overrides every mode
    if (!pins_s.cold_n) begin
      st_nxt.mode     = MODE_RUN;
      st_nxt.pd_req   = '0;
      st_nxt.env_idx  = ENV_FIRST;
      st_nxt.disp     = '0;
      // pulse stands for every cycle the synced pin stays low
      st_nxt.cold_res = 1'b1;
    end
  end

  // sequencer register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '{mode: MODE_RUN, env_idx: ENV_FIRST, pd_req: '0, disp: '0,
                warn_prev: 1'b1, warm_res: 1'b0, cold_res: 1'b0, cold_drv: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // gate enables from the mode
  always_comb begin
    gate_nxt           = gate_r;
    gate_nxt.core_en   = (st_r.mode == MODE_RUN) || (st_r.mode == MODE_PD_RTN);
    gate_nxt.global_en = (st_r.mode != MODE_PD_STOP) && (st_r.mode != MODE_STANDBY);
    // idle leaves peripheral clocks alone; each can be parked
    gate_nxt.periph_en = gate_nxt.global_en ? ~periph_low_power_i : '0;
  end

  // enables move on the falling edge, while the gated clock is low
  always_ff @(negedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gate_r <= '{core_en: 1'b1, global_en: 1'b1, periph_en: '0};
    end else begin
      gate_r <= gate_nxt;
    end
  end

  // outputs straight from flip-flops, except cold_reset_n_o which is tied low
  assign mode_o            = st_r.mode;
  assign pd_routine_req_o  = st_r.pd_req;
  assign dispatch_valid_o  = st_r.disp.valid;
  assign dispatch_env_o    = st_r.disp.env;
  assign dispatch_irq_o    = st_r.disp.irq;
  assign dispatch_slice_o  = st_r.disp.slice;
  assign warm_resume_o     = st_r.warm_res;
  assign cold_restart_o    = st_r.cold_res;
  assign cold_reset_n_o    = 1'b0;  // open collector: only ever pulls low
  assign cold_reset_n_oe_o = st_r.cold_drv;
  assign core_clk_en_o     = gate_r.core_en;
  assign global_clk_en_o   = gate_r.global_en;
  assign periph_clk_en_o   = gate_r.periph_en;

endmodule : power_mode_sequencer
`default_nettype wire

// >>> power_mode_sequencer_asserts.sv
// port-level checks of the power-mode sequencer
`timescale 1ns/1ps
`default_nettype none
module power_mode_sequencer_asserts
  import power_mode_pkg::*;
(
  input wire logic                  ref_clk_i,
  input wire logic                  nrst_i,
  input wire logic                  power_down_warning_n_i,
  input wire logic                  wakeup_pin_n_i,
  input wire logic                  run_queue_empty_i,
  input wire logic [IRQ_W-1:0]      irq_req_i,
  input wire logic [IRQ_W-1:0]      irq_mask_i,
  input wire logic [NUM_ENV-1:0]    pd_routine_req_o,
  input wire logic [NUM_ENV-1:0]    pd_routine_done_i,
  input wire logic [NUM_PERIPH-1:0] periph_low_power_i,
  input wire logic                  dispatch_valid_o,
  input wire logic [ENV_IDX_W-1:0]  dispatch_env_o,
  input wire logic [IRQ_IDX_W-1:0]  dispatch_irq_o,
  input wire logic                  warm_resume_o,
  input wire logic                  cold_restart_o,
  input wire logic                  core_clk_en_o,
  input wire logic                  global_clk_en_o,
  input wire logic [NUM_PERIPH-1:0] periph_clk_en_o,
  input wire mode_t                 mode_o
);
  logic [IRQ_W-1:0] live;  // unmasked requests
  assign live = irq_req_i & ~irq_mask_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  AST_IDLE_ENTRY: assert property (mode_o == MODE_IDLE && $past(mode_o) == MODE_RUN
    |-> $past(run_queue_empty_i) && $past(live) == 0) else $error("bad idle entry");
  AST_IDLE_GATE: assert property (mode_o == MODE_IDLE && $past(mode_o) == MODE_IDLE
    |-> !core_clk_en_o && periph_clk_en_o == ~$past(periph_low_power_i))
    else $error("bad idle gating");
  AST_IRQ_WAKE: assert property (mode_o == MODE_IDLE && live != 0
    |=> mode_o inside {MODE_RUN, MODE_PD_RTN}) else $error("irq kept idle");
  AST_DISPATCH: assert property (dispatch_valid_o |-> $past(mode_o) == MODE_IDLE
    && dispatch_env_o == IRQ_ENV_MAP[dispatch_irq_o] ##1 !dispatch_valid_o)
    else $error("bad dispatch");
  AST_PD_START: assert property (mode_o == MODE_PD_RTN && $past(mode_o) != MODE_PD_RTN
    |-> pd_routine_req_o == 2'h1 && !$past(power_down_warning_n_i)) else $error("bad pd start");
  AST_PD_ORDER: assert property (mode_o == MODE_PD_STOP && $past(mode_o) == MODE_PD_RTN
    |-> $past(pd_routine_req_o) == 2'h2 && $past(pd_routine_done_i[1])) else $error("pd order");
  AST_PD_STOP_CLK: assert property ($past(mode_o) == MODE_PD_STOP && mode_o == MODE_PD_STOP
    |-> !global_clk_en_o && !core_clk_en_o && periph_clk_en_o == 0) else $error("pd clocks");
  AST_STANDBY_EXIT: assert property ($past(mode_o) == MODE_STANDBY && mode_o == MODE_RUN
    |-> !warm_resume_o && (cold_restart_o || !$past(wakeup_pin_n_i))) else $error("bad wake");
  cover property (dispatch_valid_o && dispatch_irq_o == SLICE_IRQ_IDX);
  cover property (warm_resume_o);
  cover property (mode_o == MODE_STANDBY ##1 mode_o == MODE_RUN);
endmodule : power_mode_sequencer_asserts
bind power_mode_sequencer power_mode_sequencer_asserts u_chk (.ref_clk_i, .nrst_i,
  .power_down_warning_n_i, .wakeup_pin_n_i, .run_queue_empty_i, .irq_req_i, .irq_mask_i,
  .pd_routine_req_o, .pd_routine_done_i, .periph_low_power_i, .dispatch_valid_o,
  .dispatch_env_o, .dispatch_irq_o, .warm_resume_o, .cold_restart_o, .core_clk_en_o,
  .global_clk_en_o, .periph_clk_en_o, .mode_o);
`default_nettype wire

// >>> supply_wake_model.sv
// supply supervision and wake logic driving the active-low pins
`timescale 1ns/1ps
`default_nettype none
module supply_wake_model (
  input  wire logic       ref_clk_i,  // reference clock
  input  wire logic [1:0] ev_i,       // 0 warn, 1 wake, 2 warm, 3 cold
  input  wire logic       ev_go_i,    // start one event
  input  wire logic [3:0] dly_i,      // answer delay in cycles
  input  wire logic       dut_oe_i,   // device pulls cold reset
  output logic            warn_n_o,
  output logic            wake_n_o,
  output logic            warm_n_o,
  output logic            cold_n_o
);
  logic [3:0] drv = 4'h0;  // pulls low, released pins float up
  logic [1:0] e;           // event in progress
  // delayed low pulse of 8 cycles on the chosen pin
  always @(negedge ref_clk_i) if (ev_go_i) begin
    e = ev_i;
    repeat (dly_i) @(negedge ref_clk_i);
    drv[e] <= 1'b1;
    repeat (8) @(negedge ref_clk_i);
    drv[e] <= 1'b0;
  end
  assign warn_n_o = ~drv[0];
  assign wake_n_o = ~drv[1];
  assign warm_n_o = ~drv[2];
  assign cold_n_o = ~(drv[3] | dut_oe_i);
endmodule : supply_wake_model
`default_nettype wire

// >>> power_mode_sequencer_tb.sv
// self-checking bench of the power-mode sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin failures++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module power_mode_sequencer_tb;
  import power_mode_pkg::*;
  logic                  clk, nrst_n, rqe, sb, trr, go, wrn, wak, wrm, cld;
  logic                  oe, dv, dsl, wp, cp, cen, gen, cold_o;
  logic [ENV_IDX_W-1:0]  denv;
  logic [IRQ_IDX_W-1:0]  dirq;
  logic [IRQ_W-1:0]      irq, msk;
  logic [NUM_ENV-1:0]    pdr, done;
  logic [NUM_PERIPH-1:0] lp, pen;
  logic [1:0]            ev;
  logic [3:0]            dly;
  logic [31:0]           seed = 32'h17A2;
  mode_t                 mode, last = MODE_RUN, em;
  mode_t                 mq[$];  // expected modes
  logic [4:0]            dq[$];  // expected dispatch notes
  int                    failures = 0, n_compared = 0, cyc = 0;
  int                    n_warm = 0, n_cold = 0;  // restart pulse cycles seen
  logic [4:0]            ed;                      // oldest dispatch note
  power_mode_sequencer DUT (.ref_clk_i(clk), .nrst_i(nrst_n), .power_down_warning_n_i(wrn),
    .wakeup_pin_n_i(wak), .warm_reset_n_i(wrm), .cold_reset_n_i(cld), .cold_reset_n_o(cold_o),
    .cold_reset_n_oe_o(oe), .test_reset_req_i(trr), .run_queue_empty_i(rqe), .irq_req_i(irq),
    .irq_mask_i(msk), .standby_instr_i(sb), .pd_routine_req_o(pdr), .pd_routine_done_i(done),
    .periph_low_power_i(lp), .dispatch_valid_o(dv), .dispatch_env_o(denv),
    .dispatch_irq_o(dirq), .dispatch_slice_o(dsl), .warm_resume_o(wp), .cold_restart_o(cp),
    .core_clk_en_o(cen), .global_clk_en_o(gen), .periph_clk_en_o(pen), .mode_o(mode));
  supply_wake_model u_sup (.ref_clk_i(clk), .ev_i(ev), .ev_go_i(go), .dly_i(dly),
    .dut_oe_i(oe), .warn_n_o(wrn), .wake_n_o(wak), .warm_n_o(wrm), .cold_n_o(cld));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic final_report;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic wait_mode(input mode_t m);  // bounded wait, then settle gates
    int n;
    n = 0;
    while (mode !== m && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n == 60) begin
      failures++;
      final_report();
    end
    @(negedge clk);
  endtask : wait_mode
  task automatic pin(input logic [1:0] e);  // one supply event at a random delay
    seed = lfsr(seed);
    ev <= e;
    dly <= seed[3:0];
    go <= 1'b1;
    @(negedge clk);
    go <= 1'b0;
    repeat (32) @(negedge clk);
  endtask : pin
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // cycle ceiling against hangs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      final_report();
    end
  end
  // monitor: every mode change and dispatch takes the oldest note
  always @(negedge clk) if (nrst_n) begin
    if (mode !== last) begin
      em = (mq.size() > 0) ? mq.pop_front() : last;
      `CHK("mode", em, mode)
      last = mode;
    end
    if (dv === 1'b1) begin
      // pop once; an unexpected dispatch meets an unknown note and fails
      ed = (dq.size() > 0) ? dq.pop_front() : 'x;
      `CHK("dispatch", ed, {denv, dirq, dsl})
    end
    if (wp === 1'b1) n_warm++;
    if (cp === 1'b1) n_cold++;
  end
  initial begin
    {nrst_n, rqe, sb, trr, go, irq, msk, done, lp, ev, dly} = '0;
    repeat (12) @(negedge clk);
    nrst_n <= 1'b1;
    repeat (6) @(negedge clk);
    for (int i = 0; i < IRQ_W; i++) begin  // idle round trip per line, masked first
      seed = lfsr(seed);
      lp <= seed[7:0];
      mq.push_back(MODE_IDLE);
      rqe <= 1'b1;
      irq <= '0;
      wait_mode(MODE_IDLE);
      `CHK("core_en", 1'b0, cen)
      `CHK("periph_en", ~lp, pen)
      msk <= 8'h01 << i;
      irq <= 8'h01 << i;
      repeat (4) @(negedge clk);
      dq.push_back({IRQ_ENV_MAP[i], 3'(i), i == 0});
      mq.push_back(MODE_RUN);
      msk <= '0;
      wait_mode(MODE_RUN);
    end
    rqe <= 1'b0;
    pin(1);  // wake while running changes nothing
    mq.push_back(MODE_STANDBY);
    sb <= 1'b1;
    @(negedge clk);
    sb <= 1'b0;
    wait_mode(MODE_STANDBY);
    `CHK("core_en", 1'b0, cen)
    pin(2);  // warm pin and live irq leave standby alone
    mq.push_back(MODE_RUN);
    pin(1);
    `CHK("core_en", 1'b1, cen)
    for (int k = 2; k < 4; k++) begin  // power-down left by warm, then by cold reset
      mq.push_back(MODE_PD_RTN);
      pin(0);
      done <= 2'h2;
      @(negedge clk);
      `CHK("pd_req", 2'h1, pdr)
      done <= 2'h1;
      @(negedge clk);
      `CHK("pd_req", 2'h2, pdr)
      mq.push_back(MODE_PD_STOP);
      done <= 2'h2;
      wait_mode(MODE_PD_STOP);
      done <= 2'h0;
      `CHK("glob_en", 1'b0, gen)
      mq.push_back(MODE_RUN);
      pin(2'(k));
      `CHK("core_en", 1'b1, cen)
      `CHK("warm_pulses", 1, n_warm)
    end
    `CHK("cold_cycles", 8, n_cold)
    trr <= 1'b1;
    repeat (8) @(negedge clk);
    `CHK("cold_restart", 1'b1, cp)
    `CHK("cold_drive", 1'b1, oe)
    `CHK("cold_level", 1'b0, cold_o)
    trr <= 1'b0;
    repeat (12) @(negedge clk);
    `CHK("cold_restart", 1'b0, cp)
    `CHK("cold_drive", 1'b0, oe)
    final_report();
  end
endmodule : power_mode_sequencer_tb
`default_nettype wire
